// File: hw/igc_top.sv
// Image geometry stage: frame store, reduce, mirror, crop, register file
//
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module igc_top #(
  parameter int         SENSOR_W = 5496,
  parameter int         SENSOR_H = 3672,
  parameter int         ADC_BITS = 12,
  parameter logic       COLOUR   = 1'b1,
  parameter logic [1:0] BASE_CFA = 2'h0
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        in_valid_i,
  input  wire logic        in_sof_i,
  input  wire logic [15:0] in_data_i,
  output logic             in_ready_o,
  output logic             out_valid_o,
  input  wire logic        out_ready_i,
  output logic      [15:0] out_data_o,
  output logic             out_sof_o,
  output logic             out_eol_o,
  output logic             out_eof_o
);
  localparam int CWX   = $clog2(SENSOR_W + 1);
  localparam int CWY   = $clog2(SENSOR_H + 1);
  localparam int DEPTH = SENSOR_W * SENSOR_H;
  localparam int AW    = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
  localparam logic [15:0] DR_MAX16 = 16'(((1 << ADC_BITS) - 1) << (16 - ADC_BITS));
  localparam igc_pkg::igc_fmt_t FMT_RST =
    COLOUR ? igc_pkg::IGC_FMT_BAYER8 : igc_pkg::IGC_FMT_MONO8;

  typedef struct packed {
    igc_pkg::igc_state_t    st;
    logic [DEPTH-1:0][15:0] mem;
    logic [AW-1:0]          widx;
    logic [CWX-1:0]         ox;
    logic [CWY-1:0]         oy;
    logic [CWX-1:0]         width;
    logic [CWY-1:0]         height;
    logic [CWX-1:0]         offx;
    logic [CWY-1:0]         offy;
    logic [3:0]             ci;
    logic [3:0]             cj;
    logic [23:0]            acc;
    logic [15:0]            pix;
    logic                   psof;
    logic                   peol;
    logic                   peof;
    logic                   rev_x;
    logic                   rev_y;
    logic                   core_en;
    igc_pkg::igc_fmt_t      fmt;
    logic                   bsel;
    logic                   dsel;
    logic [1:0][1:0]        bh;
    logic [1:0][1:0]        bv;
    logic [1:0][1:0]        dh;
    logic [1:0][1:0]        dv;
    logic                   ack;
    logic [31:0]            rdat;
  } igc_state_s_t;

  igc_state_s_t q;
  igc_state_s_t n;

  logic [2:0]      bh_s;
  logic [2:0]      bv_s;
  logic [2:0]      dh_s;
  logic [2:0]      dv_s;
  logic [2:0]      hb;
  logic [2:0]      vb;
  logic [2:0]      hr;
  logic [2:0]      vr;
  logic [CWX-1:0]  max_cols;
  logic [CWY-1:0]  max_rows;
  logic [CWX-1:0]  w_eff;
  logic [CWY-1:0]  h_eff;
  logic [CWX-1:0]  offx_eff;
  logic [CWY-1:0]  offy_eff;
  logic [CWX-1:0]  sx;
  logic [CWY-1:0]  sy;
  logic [AW-1:0]   raddr;
  logic [15:0]     rd_px;
  logic [23:0]     acc_n;
  logic [23:0]     avg;
  logic            last_ci;
  logic            last_cj;
  logic            is8;
  logic            is_bayer;
  logic            req;
  logic            wr;
  logic [7:0]      adr;
  logic [2:0]      fl;
  igc_pkg::igc_cfa_t cfa;

  // Factor value to log2; only 1, 2 and 4 are accepted
  function automatic logic [2:0] igc_f2l(input logic [31:0] v);
    case (v)
      32'h0000_0001: return 3'b100;
      32'h0000_0002: return 3'b101;
      32'h0000_0004: return 3'b110;
      default:       return 3'b000;
    endcase
  endfunction : igc_f2l

  // Readback of a stored log2 as the factor value
  function automatic logic [31:0] igc_l2f(input logic [1:0] l);
    return {29'h0000_0000, 3'(3'h1 << l)};
  endfunction : igc_l2f

  ////////////////////////////////////////////////////////////////////////////
  // Effective reduction per axis
  // Both binning engines add up while core_en is set; otherwise engine 0 alone
  assign bh_s = {1'b0, q.bh[0]} + (q.core_en ? {1'b0, q.bh[1]} : 3'h0);
  assign bv_s = {1'b0, q.bv[0]} + (q.core_en ? {1'b0, q.bv[1]} : 3'h0);
  assign dh_s = {1'b0, q.dh[0]} + (q.core_en ? {1'b0, q.dh[1]} : 3'h0);
  assign dv_s = {1'b0, q.dv[0]} + (q.core_en ? {1'b0, q.dv[1]} : 3'h0);
  assign hb = (dh_s == 3'h0) ? bh_s : 3'h0;
  assign vb = (dv_s == 3'h0) ? bv_s : 3'h0;
  assign hr = hb + ((bh_s == 3'h0) ? dh_s : 3'h0);
  assign vr = vb + ((bv_s == 3'h0) ? dv_s : 3'h0);

  igc_axis #(.SENSOR(SENSOR_W), .CW(CWX)) u_axis_x (
    .red_log_i  (hr),
    .size_i     (q.width),
    .off_i      (q.offx),
    .pos_i      (q.ox),
    .rev_i      (q.rev_x),
    .cell_i     (q.ci),
    .max_o      (max_cols),
    .size_eff_o (w_eff),
    .off_eff_o  (offx_eff),
    .src_o      (sx)
  );

  igc_axis #(.SENSOR(SENSOR_H), .CW(CWY)) u_axis_y (
    .red_log_i  (vr),
    .size_i     (q.height),
    .off_i      (q.offy),
    .pos_i      (q.oy),
    .rev_i      (q.rev_y),
    .cell_i     (q.cj),
    .max_o      (max_rows),
    .size_eff_o (h_eff),
    .off_eff_o  (offy_eff),
    .src_o      (sy)
  );

  // Source cell in the frame store
  assign raddr = AW'(AW'(sy) * AW'(SENSOR_W) + AW'(sx));
  assign rd_px = q.mem[raddr];
  assign acc_n = q.acc + 24'(rd_px);
  assign avg = acc_n >> ({1'b0, hb} + {1'b0, vb});
  // Decimation window is a single cell
  assign last_ci = (q.ci == 4'((5'h01 << hb) - 5'h01));
  assign last_cj = (q.cj == 4'((5'h01 << vb) - 5'h01));

  assign is8 = ~q.fmt[0];
  assign is_bayer = q.fmt[1];
  // Column phase follows the horizontal flip
  // Row phase follows the vertical flip
  assign cfa = is_bayer ? igc_pkg::igc_cfa_t'({1'b0, BASE_CFA ^ {q.rev_y, q.rev_x}})
                        : igc_pkg::IGC_CFA_NONE;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: one wait state, unmapped words read zero
  assign req = wb_cyc_i & wb_stb_i & ~q.ack;
  assign wr  = req & wb_we_i & (wb_sel_i[1:0] == 2'b11);
  assign adr = {wb_adr_i[7:2], 2'b00};
  assign fl  = igc_f2l(wb_dat_i);

  ////////////////////////////////////////////////////////////////////////////
  // Next state of everything
  always_comb begin
    n = q;
    n.ack = req;
    // Read mux, sampled when the request is taken
    if (req) begin
      case (adr)
        igc_pkg::IGC_OFS_SENSOR_W: n.rdat = 32'(SENSOR_W);
        igc_pkg::IGC_OFS_SENSOR_H: n.rdat = 32'(SENSOR_H);
        igc_pkg::IGC_OFS_MAX_COLS: n.rdat = 32'(max_cols);
        igc_pkg::IGC_OFS_MAX_ROWS: n.rdat = 32'(max_rows);
        igc_pkg::IGC_OFS_WIDTH:    n.rdat = 32'(w_eff);
        igc_pkg::IGC_OFS_HEIGHT:   n.rdat = 32'(h_eff);
        igc_pkg::IGC_OFS_OFF_X:    n.rdat = 32'(offx_eff);
        igc_pkg::IGC_OFS_OFF_Y:    n.rdat = 32'(offy_eff);
        igc_pkg::IGC_OFS_FORMAT:   n.rdat = 32'(q.fmt);
        igc_pkg::IGC_OFS_PIX_SIZE: n.rdat = is8 ? igc_pkg::IGC_BPP8 : igc_pkg::IGC_BPP16;
        igc_pkg::IGC_OFS_CFA:      n.rdat = 32'(cfa);
        igc_pkg::IGC_OFS_DR_MIN:   n.rdat = igc_pkg::IGC_DR_MIN;
        igc_pkg::IGC_OFS_DR_MAX:   n.rdat = 32'(is8 ? igc_pkg::IGC_DR_MAX8 : DR_MAX16);
        igc_pkg::IGC_OFS_CTRL:     n.rdat = {29'h0000_0000, q.core_en, q.rev_y, q.rev_x};
        igc_pkg::IGC_OFS_BIN_SEL:  n.rdat = 32'(q.bsel);
        igc_pkg::IGC_OFS_BIN_H:    n.rdat = igc_l2f(q.bh[q.bsel]);
        igc_pkg::IGC_OFS_BIN_V:    n.rdat = igc_l2f(q.bv[q.bsel]);
        igc_pkg::IGC_OFS_DEC_SEL:  n.rdat = 32'(q.dsel);
        igc_pkg::IGC_OFS_DEC_H:    n.rdat = igc_l2f(q.dh[q.dsel]);
        igc_pkg::IGC_OFS_DEC_V:    n.rdat = igc_l2f(q.dv[q.dsel]);
        igc_pkg::IGC_OFS_STATUS:   n.rdat = 32'(q.st);
        igc_pkg::IGC_OFS_DEC_MODE: n.rdat = igc_pkg::IGC_DEC_MODE_DISCARD;
        default:                   n.rdat = 32'h0000_0000;
      endcase
    end
    // Writes; raw crop kept, clamp applied on use
    if (wr) begin
      case (adr)
        igc_pkg::IGC_OFS_WIDTH:   n.width  = wb_dat_i[CWX-1:0];
        igc_pkg::IGC_OFS_HEIGHT:  n.height = wb_dat_i[CWY-1:0];
        igc_pkg::IGC_OFS_OFF_X:   n.offx   = wb_dat_i[CWX-1:0];
        igc_pkg::IGC_OFS_OFF_Y:   n.offy   = wb_dat_i[CWY-1:0];
        igc_pkg::IGC_OFS_FORMAT: begin
          // Mono on a colour sensor needs the core
          if (wb_dat_i[31:2] == 30'h0 && (COLOUR ? (wb_dat_i[1] | q.core_en) : ~wb_dat_i[1])) begin
            n.fmt = igc_pkg::igc_fmt_t'(wb_dat_i[1:0]);
          end
        end
        igc_pkg::IGC_OFS_CTRL: begin
          n.rev_x = wb_dat_i[igc_pkg::IGC_CTRL_REV_X];
          n.rev_y = wb_dat_i[igc_pkg::IGC_CTRL_REV_Y];
          n.core_en = wb_dat_i[igc_pkg::IGC_CTRL_CORE];
          // Core off drops a colour sensor back to Bayer
          if (COLOUR && !wb_dat_i[igc_pkg::IGC_CTRL_CORE] && !q.fmt[1]) begin
            n.fmt = igc_pkg::IGC_FMT_BAYER16;
          end
        end
        igc_pkg::IGC_OFS_BIN_SEL: n.bsel = wb_dat_i[0];
        igc_pkg::IGC_OFS_DEC_SEL: n.dsel = wb_dat_i[0];
        // Factors land in the selected engine
        igc_pkg::IGC_OFS_BIN_H: if (fl[2]) n.bh[q.bsel] = fl[1:0];
        igc_pkg::IGC_OFS_BIN_V: if (fl[2]) n.bv[q.bsel] = fl[1:0];
        // Factors land in the selected layer
        igc_pkg::IGC_OFS_DEC_H: if (fl[2]) n.dh[q.dsel] = fl[1:0];
        igc_pkg::IGC_OFS_DEC_V: if (fl[2]) n.dv[q.dsel] = fl[1:0];
        default: ;
      endcase
    end
    // Pixel path
    unique case (q.st)
      igc_pkg::IGC_ST_IDLE, igc_pkg::IGC_ST_CAPT: begin
        // A start flag in idle or capture restarts the store, resyncing a torn frame
        if (in_valid_i && in_sof_i) begin
          n.mem[0] = in_data_i;
          n.widx = AW'(1);
          n.st = igc_pkg::IGC_ST_CAPT;
        end else if (in_valid_i && q.st == igc_pkg::IGC_ST_CAPT) begin
          n.mem[q.widx] = in_data_i;
          n.widx = q.widx + AW'(1);
          if (q.widx == LAST_IDX) begin
            n.st = igc_pkg::IGC_ST_READ;
            n.ox = '0;
            n.oy = '0;
            n.ci = '0;
            n.cj = '0;
            n.acc = '0;
          end
        end
      end
      igc_pkg::IGC_ST_READ: begin
        // One window cell per cycle
        n.acc = acc_n;
        n.ci = last_ci ? 4'h0 : q.ci + 4'h1;
        if (last_ci) begin
          n.cj = last_cj ? 4'h0 : q.cj + 4'h1;
        end
        if (last_ci && last_cj) begin
          n.acc = '0;
          n.pix = is8 ? {8'h00, avg[15:8]} : avg[15:0];
          n.psof = (q.ox == '0) && (q.oy == '0);
          n.peol = (q.ox == w_eff - CWX'(1));
          n.peof = n.peol && (q.oy == h_eff - CWY'(1));
          n.st = igc_pkg::IGC_ST_EMIT;
        end
      end
      igc_pkg::IGC_ST_EMIT: begin
        // Held until the host takes it
        if (out_ready_i) begin
          if (q.peof) begin
            n.st = igc_pkg::IGC_ST_IDLE;
          end else begin
            n.st = igc_pkg::IGC_ST_READ;
            n.ox = q.peol ? '0 : q.ox + CWX'(1);
            n.oy = q.peol ? q.oy + CWY'(1) : q.oy;
          end
        end
      end
    endcase
    // Synchronous reset
    if (rst_i) begin
      n = '0;
      n.st = igc_pkg::IGC_ST_IDLE;
      n.width = CWX'(SENSOR_W);
      n.height = CWY'(SENSOR_H);
      n.rev_x = igc_pkg::IGC_RST_FLAG;
      n.rev_y = igc_pkg::IGC_RST_FLAG;
      n.core_en = igc_pkg::IGC_RST_FLAG;
      n.fmt = FMT_RST;
      n.bh = {2{igc_pkg::IGC_RST_LOG}};
      n.bv = {2{igc_pkg::IGC_RST_LOG}};
      n.dh = {2{igc_pkg::IGC_RST_LOG}};
      n.dv = {2{igc_pkg::IGC_RST_LOG}};
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    q <= n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign wb_ack_o    = q.ack;
  assign wb_dat_o    = q.rdat;
  assign in_ready_o  = (q.st == igc_pkg::IGC_ST_IDLE) || (q.st == igc_pkg::IGC_ST_CAPT);
  assign out_valid_o = (q.st == igc_pkg::IGC_ST_EMIT);
  assign out_data_o  = q.pix;
  assign out_sof_o   = q.psof;
  assign out_eol_o   = q.peol;
  assign out_eof_o   = q.peof;
endmodule : igc_top
`default_nettype wire

// File: hw/igc_pkg.sv
// Shared constants and types for the image geometry stage
package igc_pkg;
  // Register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] IGC_OFS_SENSOR_W = 8'h00;
  localparam logic [7:0] IGC_OFS_SENSOR_H = 8'h04;
  localparam logic [7:0] IGC_OFS_MAX_COLS = 8'h08;
  localparam logic [7:0] IGC_OFS_MAX_ROWS = 8'h0C;
  localparam logic [7:0] IGC_OFS_WIDTH    = 8'h10;
  localparam logic [7:0] IGC_OFS_HEIGHT   = 8'h14;
  localparam logic [7:0] IGC_OFS_OFF_X    = 8'h18;
  localparam logic [7:0] IGC_OFS_OFF_Y    = 8'h1C;
  localparam logic [7:0] IGC_OFS_FORMAT   = 8'h20;
  localparam logic [7:0] IGC_OFS_PIX_SIZE = 8'h24;
  localparam logic [7:0] IGC_OFS_CFA      = 8'h28;
  localparam logic [7:0] IGC_OFS_DR_MIN   = 8'h2C;
  localparam logic [7:0] IGC_OFS_DR_MAX   = 8'h30;
  localparam logic [7:0] IGC_OFS_CTRL     = 8'h34;
  localparam logic [7:0] IGC_OFS_BIN_SEL  = 8'h38;
  localparam logic [7:0] IGC_OFS_BIN_H    = 8'h3C;
  localparam logic [7:0] IGC_OFS_BIN_V    = 8'h40;
  localparam logic [7:0] IGC_OFS_DEC_SEL  = 8'h44;
  localparam logic [7:0] IGC_OFS_DEC_H    = 8'h48;
  localparam logic [7:0] IGC_OFS_DEC_V    = 8'h4C;
  localparam logic [7:0] IGC_OFS_STATUS   = 8'h50;
  localparam logic [7:0] IGC_OFS_DEC_MODE = 8'h54;
  // Control register bit positions
  localparam int IGC_CTRL_REV_X = 0;
  localparam int IGC_CTRL_REV_Y = 1;
  localparam int IGC_CTRL_CORE  = 2;
  // Values after reset
  localparam logic       IGC_RST_FLAG = 1'b0;
  localparam logic [1:0] IGC_RST_LOG  = 2'h0;
  // Read-only codes
  localparam logic [31:0] IGC_DEC_MODE_DISCARD = 32'h0000_0000;
  localparam logic [31:0] IGC_BPP8             = 32'h0000_0008;
  localparam logic [31:0] IGC_BPP16            = 32'h0000_0010;
  localparam logic [31:0] IGC_DR_MIN           = 32'h0000_0000;
  localparam logic [15:0] IGC_DR_MAX8          = 16'h00FF;

  typedef enum logic [1:0] {
    IGC_ST_IDLE = 2'b00,
    IGC_ST_CAPT = 2'b01,
    IGC_ST_READ = 2'b11,
    IGC_ST_EMIT = 2'b10
  } igc_state_t;

  typedef enum logic [1:0] {
    IGC_FMT_MONO8   = 2'h0,
    IGC_FMT_MONO16  = 2'h1,
    IGC_FMT_BAYER8  = 2'h2,
    IGC_FMT_BAYER16 = 2'h3
  } igc_fmt_t;

  typedef enum logic [2:0] {
    IGC_CFA_RED_GREEN  = 3'h0,
    IGC_CFA_GREEN_RED  = 3'h1,
    IGC_CFA_GREEN_BLUE = 3'h2,
    IGC_CFA_BLUE_GREEN = 3'h3,
    IGC_CFA_NONE       = 3'h4
  } igc_cfa_t;
endpackage : igc_pkg

// File: hw/igc_axis.sv
// One axis of the geometry: reduced size, crop clamp and source mapping
`timescale 1ns/10ps
`default_nettype none
module igc_axis #(
  parameter int SENSOR = 5496,
  parameter int CW     = $clog2(SENSOR + 1)
) (
  input  wire logic [2:0]    red_log_i,
  input  wire logic [CW-1:0] size_i,
  input  wire logic [CW-1:0] off_i,
  input  wire logic [CW-1:0] pos_i,
  input  wire logic          rev_i,
  input  wire logic [3:0]    cell_i,
  output logic      [CW-1:0] max_o,
  output logic      [CW-1:0] size_eff_o,
  output logic      [CW-1:0] off_eff_o,
  output logic      [CW-1:0] src_o
);
  logic [CW-1:0] full;
  logic [CW-1:0] room;
  logic [CW-1:0] r;
  logic [CW-1:0] u;

  assign full = CW'(SENSOR);
  assign max_o = full >> red_log_i;

  assign size_eff_o = (size_i == '0) ? CW'(1) : ((size_i > max_o) ? max_o : size_i);
  assign room = max_o - size_eff_o;
  assign off_eff_o = (off_i > room) ? room : off_i;

  // Crop position lives in flipped image
  assign r = pos_i + off_eff_o;
  assign u = rev_i ? (max_o - CW'(1) - r) : r;
  // Back to a sensor cell inside the window
  assign src_o = (u << red_log_i) + CW'(cell_i);
endmodule : igc_axis
`default_nettype wire

// File: tb/igc_checker.sv
// Port-level timing checks for the geometry stage
`timescale 1ns/10ps
`default_nettype none
module igc_checker #(
  parameter int SENSOR_W = 8
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        in_ready_o,
  input wire logic        out_valid_o,
  input wire logic        out_ready_i,
  input wire logic [15:0] out_data_o,
  input wire logic        out_sof_o,
  input wire logic        out_eol_o,
  input wire logic        out_eof_o
);
  logic req;
  logic rd;
  // Bus request taken at this edge, and its read flavour
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd  = req && !wb_we_i;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////////////////
  // Bus answers exactly one cycle after the take
  a_ack_follows: assert property (req |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_unasked: assert property (!req |=> !wb_ack_o) else $error("ack unasked");
  a_sensor_w_read: assert property (
    rd && wb_adr_i == igc_pkg::IGC_OFS_SENSOR_W |=> wb_dat_o == 32'(SENSOR_W))
    else $error("sensor width wrong");
  a_range_min_read: assert property (
    rd && wb_adr_i == igc_pkg::IGC_OFS_DR_MIN |=> wb_dat_o == igc_pkg::IGC_DR_MIN)
    else $error("range min wrong");
  // Unmapped reads return zero
  a_unmapped_zero: assert property (rd && wb_adr_i >= 8'h58 |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  // Stream holds while the host stalls
  a_out_hold: assert property (out_valid_o && !out_ready_i |=> out_valid_o
    && $stable({out_data_o, out_sof_o, out_eol_o, out_eof_o})) else $error("output moved");
  // No capture while reading out
  a_out_excl: assert property (out_valid_o |-> !in_ready_o) else $error("ready in readout");
  // frame ends on a row end
  a_eof_on_eol: assert property (out_valid_o && out_eof_o |-> out_eol_o)
    else $error("eof without eol");
  a_idle_after_eof: assert property (out_valid_o && out_ready_i && out_eof_o
    |=> in_ready_o && !out_valid_o) else $error("no idle after frame");
endmodule : igc_checker
bind igc_top igc_checker #(.SENSOR_W(SENSOR_W)) chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .in_ready_o(in_ready_o),
  .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_data_o(out_data_o),
  .out_sof_o(out_sof_o), .out_eol_o(out_eol_o), .out_eof_o(out_eof_o));
`default_nettype wire

// File: tb/igc_host_sink.sv
// Host model: takes output pixels, stalls at random when asked
`timescale 1ns/10ps
`default_nettype none
module igc_host_sink (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        stall_i,
  input  wire logic        valid_i,
  input  wire logic [15:0] data_i,
  input  wire logic [2:0]  flag_i,
  output logic             ready_o
);
  logic [31:0] lfsr_q;
  logic [18:0] got_q[$];
  // Log each accepted pixel; own LFSR keeps stalls apart from bench draws
  always @(posedge clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
      lfsr_q <= 32'h0000_ACE1;
    end else begin
      if (valid_i && ready_o) got_q.push_back({flag_i, data_i});
      lfsr_q <= {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      ready_o <= !stall_i || lfsr_q[0];
    end
  end
endmodule : igc_host_sink
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the image geometry stage
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int W = 8;
  localparam int H = 4;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, stall;
  logic in_valid_i, in_sof_i, in_ready_o, out_valid_o, out_ready_i;
  logic out_sof_o, out_eol_o, out_eof_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, seed;
  logic [15:0] in_data_i, out_data_o;
  logic [15:0] pix[W*H];
  int          n_mismatch, num_checks, b, rx, ry, cw, ch, ox, oy;
  igc_top #(.SENSOR_W(W), .SENSOR_H(H)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .in_valid_i(in_valid_i), .in_sof_i(in_sof_i), .in_data_i(in_data_i),
    .in_ready_o(in_ready_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
    .out_data_o(out_data_o), .out_sof_o(out_sof_o), .out_eol_o(out_eol_o),
    .out_eof_o(out_eof_o));
  igc_host_sink host (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .valid_i(out_valid_o),
    .data_i(out_data_o), .flag_i({out_sof_o, out_eol_o, out_eof_o}), .ready_o(out_ready_i));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // Mirror in binned space, then crop, then average the cells
  function automatic logic [15:0] exp_pix(input int r, input int c);
    int sx, sy;
    logic [19:0] sum;
    sx = rx ? W / b - 1 - ox - c : ox + c;
    sy = ry ? H / b - 1 - oy - r : oy + r;
    sum = 20'h0_0000;
    for (int i = 0; i < b; i++)
      for (int j = 0; j < b; j++)
        sum += 20'(pix[(sy * b + i) * W + sx * b + j]);
    sum = sum >> (2 * $clog2(b));
    return {8'h00, sum[15:8]};
  endfunction : exp_pix
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask : check
  // Classic single cycle; held until ack is sampled high
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= s;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    if (n >= 50) n_mismatch++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input int d);
    bus(1'b1, a, 32'(d));
  endtask : wr
  task automatic rchk(input logic [7:0] a, input int e);
    bus(1'b0, a, 32'h0000_0000);
    check(rd, 32'(e), "register read");
  endtask : rchk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  // Configure, push one random frame, compare the stream
  task automatic frame(input int bb, x, y, w, h, px, py);
    int n;
    b = bb; rx = x; ry = y; cw = w; ch = h; ox = px; oy = py;
    wr(igc_pkg::IGC_OFS_BIN_H, bb);
    wr(igc_pkg::IGC_OFS_BIN_V, bb);
    wr(igc_pkg::IGC_OFS_CTRL, y * 2 + x);
    wr(igc_pkg::IGC_OFS_WIDTH, w);
    wr(igc_pkg::IGC_OFS_HEIGHT, h);
    wr(igc_pkg::IGC_OFS_OFF_X, px);
    wr(igc_pkg::IGC_OFS_OFF_Y, py);
    rchk(igc_pkg::IGC_OFS_MAX_COLS, W / bb);
    rchk(igc_pkg::IGC_OFS_MAX_ROWS, H / bb);
    rchk(igc_pkg::IGC_OFS_CFA, y * 2 + x);
    for (int i = 0; i < W * H; i++) begin
      seed = xs(seed);
      pix[i] = seed[15:0];
    end
    host.got_q.delete();
    for (int i = 0; i < W * H; i++) begin
      @(posedge clk_i);
      in_valid_i <= 1'b1;
      in_sof_i <= (i == 0);
      in_data_i <= pix[i];
    end
    @(posedge clk_i);
    in_valid_i <= 1'b0;
    n = 0;
    while (host.got_q.size() < w * h && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    repeat (5) @(posedge clk_i);
    check(32'(host.got_q.size()), 32'(w * h), "pixel count");
    foreach (host.got_q[k]) begin
      check(32'(host.got_q[k][15:0]), 32'(exp_pix(k / w, k % w)), "pixel");
      check(32'(host.got_q[k][18:16]), {29'h0, k == 0, k % w == w - 1, k == w * h - 1},
        "flags");
    end
    $display("frame bin %0d rev %0d%0d done", bb, y, x);
  endtask : frame
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    n_mismatch++;
    stop_test();
  end
  initial begin
    rst_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = 8'h00;
    wb_dat_i = 32'h0000_0000; in_valid_i = 1'b0; in_sof_i = 1'b0; in_data_i = 16'h0000;
    wb_sel_i = 4'h0;
    stall = 1'b0; seed = 32'h1f8f91f9; n_mismatch = 0; num_checks = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(igc_pkg::IGC_OFS_SENSOR_H, H);
    wr(igc_pkg::IGC_OFS_SENSOR_W, 3);
    rchk(igc_pkg::IGC_OFS_SENSOR_W, W);
    rchk(igc_pkg::IGC_OFS_PIX_SIZE, igc_pkg::IGC_BPP8);
    rchk(igc_pkg::IGC_OFS_DR_MIN, igc_pkg::IGC_DR_MIN);
    rchk(igc_pkg::IGC_OFS_DR_MAX, igc_pkg::IGC_DR_MAX8);
    rchk(igc_pkg::IGC_OFS_DEC_MODE, igc_pkg::IGC_DEC_MODE_DISCARD);
    rchk(8'h58, 0);
    // binning and decimation exclude each other
    wr(igc_pkg::IGC_OFS_DEC_H, 2);
    rchk(igc_pkg::IGC_OFS_MAX_COLS, W / 2);
    wr(igc_pkg::IGC_OFS_BIN_H, 2);
    rchk(igc_pkg::IGC_OFS_MAX_COLS, W);
    wr(igc_pkg::IGC_OFS_DEC_H, 1);
    wr(igc_pkg::IGC_OFS_BIN_H, 1);
    // second engine only with core enabled
    wr(igc_pkg::IGC_OFS_BIN_SEL, 1);
    wr(igc_pkg::IGC_OFS_BIN_H, 2);
    rchk(igc_pkg::IGC_OFS_BIN_H, 2);
    rchk(igc_pkg::IGC_OFS_MAX_COLS, W);
    wr(igc_pkg::IGC_OFS_CTRL, 4);
    rchk(igc_pkg::IGC_OFS_MAX_COLS, W / 2);
    wr(igc_pkg::IGC_OFS_BIN_H, 1);
    wr(igc_pkg::IGC_OFS_BIN_SEL, 0);
    wr(igc_pkg::IGC_OFS_DEC_SEL, 1);
    wr(igc_pkg::IGC_OFS_DEC_V, 2);
    rchk(igc_pkg::IGC_OFS_MAX_ROWS, H / 2);
    wr(igc_pkg::IGC_OFS_DEC_V, 1);
    wr(igc_pkg::IGC_OFS_DEC_SEL, 0);
    rchk(igc_pkg::IGC_OFS_BIN_H, 1);
    wr(igc_pkg::IGC_OFS_FORMAT, igc_pkg::IGC_FMT_MONO8);
    rchk(igc_pkg::IGC_OFS_CFA, igc_pkg::IGC_CFA_NONE);
    wr(igc_pkg::IGC_OFS_CTRL, 0);
    rchk(igc_pkg::IGC_OFS_FORMAT, igc_pkg::IGC_FMT_BAYER16);
    wr(igc_pkg::IGC_OFS_FORMAT, igc_pkg::IGC_FMT_MONO8);
    rchk(igc_pkg::IGC_OFS_FORMAT, igc_pkg::IGC_FMT_BAYER16);
    wr(igc_pkg::IGC_OFS_FORMAT, igc_pkg::IGC_FMT_BAYER16);
    rchk(igc_pkg::IGC_OFS_PIX_SIZE, igc_pkg::IGC_BPP16);
    rchk(igc_pkg::IGC_OFS_DR_MAX, 32'h0000_FFF0);
    rchk(igc_pkg::IGC_OFS_CFA, igc_pkg::IGC_CFA_RED_GREEN);
    wr(igc_pkg::IGC_OFS_FORMAT, igc_pkg::IGC_FMT_BAYER8);
    wr(igc_pkg::IGC_OFS_CTRL, 0);
    wr(igc_pkg::IGC_OFS_WIDTH, 0);
    rchk(igc_pkg::IGC_OFS_WIDTH, 1);
    wr(igc_pkg::IGC_OFS_WIDTH, 3);
    wr(igc_pkg::IGC_OFS_OFF_X, 7);
    rchk(igc_pkg::IGC_OFS_OFF_X, W - 3);
    bus(1'b1, igc_pkg::IGC_OFS_WIDTH, 32'h0000_0005, 4'hC);
    rchk(igc_pkg::IGC_OFS_WIDTH, 3);
    $display("register tests done");
    frame(1, 0, 0, W, H, 0, 0);
    frame(1, 1, 0, W, H, 0, 0);
    frame(1, 0, 1, 5, 3, 2, 1);
    frame(1, 1, 1, 3, 2, 4, 2);
    frame(2, 1, 0, 3, 2, 1, 0);
    frame(4, 0, 1, 2, 1, 0, 0);
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      stall <= seed[3];
      b = seed[0] ? 2 : 1;
      cw = 1 + int'(seed[10:8]) % (W / b);
      ch = 1 + int'(seed[12:11]) % (H / b);
      frame(b, int'(seed[1]), int'(seed[2]), cw, ch, int'(seed[19:16]) % (W / b - cw + 1),
        int'(seed[21:20]) % (H / b - ch + 1));
    end
    stop_test();
  end
endmodule : testbench
`default_nettype wire
